// [rtl/dtm_pkg.sv]
/*
 * constants, field positions and the state type of the test-mode sequencer.
 * assumes a 10 MHz reference clock; all times below derive from it.
 */
package dtm_pkg;

	localparam int unsigned CLK_KHZ          = 10000;

	// standby windows and periods, each in its own unit
	localparam int unsigned SMOKE_WIN_US     = 5000;
	localparam int unsigned LB_WIN_US        = 10000;
	localparam int unsigned LED_WIN_US       = 10000;
	localparam int unsigned CHAMBER_LOW_MS   = 3700;
	localparam int unsigned TICK_S           = 10;
	localparam int unsigned HALF_PHASE_MS    = 500;
	localparam int unsigned LB_PERIOD_S      = 80;
	localparam int unsigned CHAMBER_PERIOD_S = 320;
	localparam int unsigned EOL_PERIOD_S     = 1310400;
	localparam int unsigned HUSH_SHORT_S     = 80;
	localparam int unsigned HUSH_LONG_MIN    = 9;

	localparam int unsigned SMOKE_WIN_CYC    = SMOKE_WIN_US * CLK_KHZ / 1000;
	localparam int unsigned LB_WIN_CYC       = LB_WIN_US * CLK_KHZ / 1000;
	localparam int unsigned LED_WIN_CYC      = LED_WIN_US * CLK_KHZ / 1000;
	localparam int unsigned CHAMBER_LOW_CYC  = CHAMBER_LOW_MS * CLK_KHZ;
	localparam int unsigned TICK_CYC         = TICK_S * CLK_KHZ * 1000;
	localparam int unsigned HALF_PHASE_CYC   = HALF_PHASE_MS * CLK_KHZ;

	// periods counted in standby ticks
	localparam int unsigned LB_TICKS         = LB_PERIOD_S / TICK_S;
	localparam int unsigned CHAMBER_TICKS    = CHAMBER_PERIOD_S / TICK_S;
	localparam int unsigned EOL_TICKS        = EOL_PERIOD_S / TICK_S;
	localparam int unsigned HUSH_SHORT_TICKS = HUSH_SHORT_S / TICK_S;
	localparam int unsigned HUSH_LONG_TICKS  = HUSH_LONG_MIN * 60 / TICK_S;

	// test modes reached by mode-step pulses
	localparam logic [4:0] MODE_HORN         = 5'h03;
	localparam logic [4:0] MODE_LOW_BATTERY  = 5'h11;
	localparam logic [4:0] MODE_SERIAL       = 5'h12;
	localparam logic [4:0] MODE_LOCK         = 5'h13;
	localparam logic [4:0] MODE_MAX          = 5'h1F;

	// user_feature_calibration_word, index = printed bit number minus one
	localparam int unsigned CFG_BITS         = 35;
	localparam int unsigned BIT_TONE         = 0;
	localparam int unsigned BIT_HUSH_DIS     = 1;
	localparam int unsigned BIT_HUSH_IN_ALARM_ONLY         = 2;
	localparam int unsigned BIT_SMART        = 3;
	localparam int unsigned BIT_HUSH_TO      = 4;
	localparam int unsigned BIT_EOL_EN       = 14;
	localparam logic [34:0] CFG_RESET        = 35'h0_0000_0000;
	localparam logic [5:0]  CFG_COUNT_FULL   = 6'h23;

	// synchronised pin inputs
	localparam int unsigned NPIN             = 9;
	localparam int unsigned PIN_TEST         = 0;
	localparam int unsigned PIN_IO           = 1;
	localparam int unsigned PIN_FEED         = 2;
	localparam int unsigned PIN_STEP         = 3;
	localparam int unsigned PIN_LOWBAT       = 4;
	localparam int unsigned PIN_HIGH_SMOKE   = 5;
	localparam int unsigned PIN_REMOTE       = 6;
	localparam int unsigned PIN_LOCAL        = 7;
	localparam int unsigned PIN_BUTTON       = 8;

	localparam int unsigned NWIN             = 4;
	localparam int unsigned WIN_SMOKE        = 0;
	localparam int unsigned WIN_LB           = 1;
	localparam int unsigned WIN_LED          = 2;
	localparam int unsigned WIN_CHAMBER      = 3;

	localparam int unsigned LIFE_W           = 16;

	typedef enum logic [1:0] {
		ST_BASE = 2'b00,
		ST_TEST = 2'b01,
		ST_HORN = 2'b11
	} dtm_state_type;

endpackage

// [rtl/dtm_sequencer.sv]
/*
 * test-mode sequencer, user feature decode and standby check schedule.
 * assumes all pin and comparator inputs are asynchronous to ref_clk_i and
 * that reset_i is the power-on reset of the whole detector.
 */

// Contract
// RL1: hush timeout 80 s or 9 min
// RL2: smart hush cancels on high/remote smoke
// RL3: hush on button release only in smoke
// RL4: hush disable bit kills hush
// RL5: tone bit picks continuous or temporal horn
// RL6: power up base, step high gives mode zero
// RL7: step pulse with test high advances mode
// RL8: horn mode: test falling enables horn forever
// RL9: mode 17: io rise starts battery test, led
// RL10: monitor output follows low battery flag
// RL11: mode 19: io pulse, test high sets lock
// RL12: mode 19: io pulse, test low clears lock
// RL13: lock set blocks config store
// RL14: smoke check 5 ms every 10 s
// RL15: unloaded battery check 10 ms every 80 s
// RL16: led loaded check 10 ms every 320 s
// RL17: chamber low 3.7 s every 320 s
// RL18: life count incremented every 1310400 s
// RL19: serial mode shifts 35 bits, io stores
// RL20: mode counter cleared only by reset
// RL21: step pulses ignored while test low
module dtm_sequencer
	import dtm_pkg::*;
#(
	parameter int unsigned SMOKE_WIN   = SMOKE_WIN_CYC,
	parameter int unsigned LB_WIN      = LB_WIN_CYC,
	parameter int unsigned LED_WIN     = LED_WIN_CYC,
	parameter int unsigned CHAMBER_LOW = CHAMBER_LOW_CYC,
	parameter int unsigned TICK        = TICK_CYC,
	parameter int unsigned HALF_PHASE  = HALF_PHASE_CYC
)(
	input  wire logic              ref_clk_i,
	input  wire logic              reset_i,
	input  wire logic              test_pin_i,
	input  wire logic              io_pin_i,
	input  wire logic              feed_pin_i,
	input  wire logic              mode_step_pin_i,
	input  wire logic              battery_low_i,
	input  wire logic              high_smoke_i,
	input  wire logic              remote_smoke_i,
	input  wire logic              local_smoke_i,
	input  wire logic              push_button_check_i,
	output logic                   horn_o,
	output logic                   red_indicator_o,
	output logic                   monitor_output_o,
	output logic                   smoke_power_o,
	output logic                   lowbat_check_o,
	output logic                   chamber_low_o,
	output logic                   hush_active_o,
	output logic                   ee_write_o,
	output logic                   lock_bit_o,
	output logic [4:0]             test_mode_o,
	output logic [CFG_BITS-1:0]    config_word_o,
	output logic [LIFE_W-1:0]      life_count_o
);

	logic [NPIN-1:0]     pins_raw;
	logic [NPIN-1:0]     meta_q;
	logic [NPIN-1:0]     sync_q;
	logic [NPIN-1:0]     prev_q;
	logic [NPIN-1:0]     rise;
	logic [NPIN-1:0]     fall;

	dtm_state_type       state_q;
	dtm_state_type       state_d;
	logic [4:0]          mode_q;
	logic [4:0]          mode_d;
	logic                in_mode;
	logic                step_count;

	logic [CFG_BITS-1:0] cfg_q;
	logic [CFG_BITS-1:0] shift_q;
	logic                lock_q;
	logic                lbt_q;
	logic                serial_mode;
	logic                lock_mode;
	logic                cfg_store;
	logic                lock_write;

	logic [31:0]         tick_cnt_q;
	logic                tick;
	logic [16:0]         tick_num_q;
	logic                tick_num_wrap;
	logic                standby;
	logic [NWIN-1:0]     win_start;
	logic [NWIN-1:0]     win_on;
	logic [31:0]         win_len [NWIN];
	logic                eol_step;
	logic [LIFE_W-1:0]   life_q;

	logic                hush_q;
	logic [5:0]          hush_ticks_q;
	logic [5:0]          hush_limit;
	logic                hush_arm;
	logic                hush_cancel;
	logic                hush_expire;

	logic [31:0]         half_cnt_q;
	logic                half_tick;
	logic [2:0]          phase_q;
	logic                temporal_on;
	logic                pattern;
	logic                alarm;

	assign pins_raw = {push_button_check_i, local_smoke_i, remote_smoke_i, high_smoke_i,
		battery_low_i, mode_step_pin_i, feed_pin_i, io_pin_i, test_pin_i};

	// every pin passes two flops; edges are taken only from the second stage
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk_i)
			begin
				meta_q[gi] <= pins_raw[gi];
				sync_q[gi] <= meta_q[gi];
				prev_q[gi] <= sync_q[gi];
			end
			assign rise[gi] = sync_q[gi] & ~prev_q[gi];
			assign fall[gi] = ~sync_q[gi] & prev_q[gi];
		end
	endgenerate

	// test-mode sequencing
	assign step_count = rise[PIN_STEP] & sync_q[PIN_TEST];                    // see RL21
	assign in_mode    = (state_q == ST_TEST);

	always_comb
	begin
		state_d = state_q;
		mode_d  = mode_q;
		unique case (state_q)
			ST_BASE:
			begin
				if (rise[PIN_STEP])
				begin
					state_d = ST_TEST;                                       // see RL6
				end
			end
			ST_TEST:
			begin
				if (step_count && mode_q != MODE_MAX)
				begin
					mode_d = mode_q + 5'h01;                                 // see RL7
				end
				if (mode_q == MODE_HORN && fall[PIN_TEST])
				begin
					state_d = ST_HORN;                                       // see RL8
				end
			end
			ST_HORN:
			begin
				state_d = ST_HORN;
			end
			default:
			begin
				state_d = ST_BASE;
			end
		endcase
	end

	// only power-on reset leaves the test modes
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			state_q <= ST_BASE;                                              // see RL20
			mode_q  <= 5'h00;
		end
		else
		begin
			state_q <= state_d;
			mode_q  <= mode_d;
		end
	end

	// serial configuration and lock programming
	assign serial_mode = in_mode && mode_q == MODE_SERIAL;
	assign lock_mode   = in_mode && mode_q == MODE_LOCK;
	assign cfg_store   = serial_mode && rise[PIN_IO] && !lock_q;                 // see RL13
	assign lock_write  = lock_mode && rise[PIN_IO];

	// a short sequence stores whatever has been shifted so far
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			shift_q <= CFG_RESET;
			cfg_q   <= CFG_RESET;
			lock_q  <= 1'b0;
			lbt_q   <= 1'b0;
			life_q  <= '0;
		end
		else
		begin
			if (serial_mode && rise[PIN_FEED])
			begin
				shift_q <= {sync_q[PIN_TEST], shift_q[CFG_BITS-1:1]};        // see RL19
			end
			if (cfg_store)
			begin
				cfg_q <= shift_q;                                            // see RL19
			end
			if (lock_write)
			begin
				lock_q <= sync_q[PIN_TEST];                                  // see RL11 see RL12
			end
			if (in_mode && mode_q == MODE_LOW_BATTERY && rise[PIN_IO])
			begin
				lbt_q <= 1'b1;                                               // see RL9
			end
			if (eol_step)
			begin
				life_q <= life_q + LIFE_W'(1);                               // see RL18
			end
		end
	end

	// standby schedule; counting in 10 s ticks keeps long periods in 17 bits
	assign standby       = (state_q == ST_BASE);
	assign tick          = standby && tick_cnt_q == TICK - 1;
	assign tick_num_wrap = tick_num_q == 17'(EOL_TICKS - 1);

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			tick_cnt_q <= 32'h0000_0000;
			tick_num_q <= 17'h0_0000;
		end
		else
		begin
			tick_cnt_q <= (tick || !standby) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
			if (tick)
			begin
				tick_num_q <= tick_num_wrap ? 17'h0_0000 : tick_num_q + 17'h0_0001;
			end
		end
	end

	assign win_start[WIN_SMOKE]   = tick;                                    // see RL14
	assign win_start[WIN_LB]      = tick && tick_num_q[2:0] == 3'(LB_TICKS);  // see RL15
	assign win_start[WIN_LED]     = tick && tick_num_q[4:0] == 5'h00;         // see RL16
	assign win_start[WIN_CHAMBER] = tick && tick_num_q[4:0] == 5'h00;         // see RL17
	assign win_len[WIN_SMOKE]     = SMOKE_WIN;
	assign win_len[WIN_LB]        = LB_WIN;
	assign win_len[WIN_LED]       = LED_WIN;
	assign win_len[WIN_CHAMBER]   = CHAMBER_LOW;

	generate
		for (gi = 0; gi < NWIN; gi++)
		begin : g_win
			logic [31:0] left_q;
			always_ff @(posedge ref_clk_i)
			begin
				if (reset_i)
				begin
					left_q <= 32'h0000_0000;
				end
				else if (win_start[gi])
				begin
					left_q <= win_len[gi];
				end
				else if (left_q != 32'h0000_0000)
				begin
					left_q <= left_q - 32'h0000_0001;
				end
			end
			assign win_on[gi] = (left_q != 32'h0000_0000);
		end
	endgenerate

	assign eol_step = tick && tick_num_wrap && cfg_q[BIT_EOL_EN];

	// hush
	assign hush_limit  = cfg_q[BIT_HUSH_TO] ? 6'(HUSH_SHORT_TICKS)
		: 6'(HUSH_LONG_TICKS);                                               // see RL1
	assign hush_arm    = fall[PIN_BUTTON] && !cfg_q[BIT_HUSH_DIS]             // see RL4
		&& (!cfg_q[BIT_HUSH_IN_ALARM_ONLY] || sync_q[PIN_LOCAL]);                          // see RL3
	assign hush_cancel = cfg_q[BIT_SMART]
		&& (sync_q[PIN_HIGH_SMOKE] || sync_q[PIN_REMOTE]);                   // see RL2
	assign hush_expire = hush_q && tick && hush_ticks_q + 6'h01 >= hush_limit;

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			hush_q       <= 1'b0;
			hush_ticks_q <= 6'h00;
		end
		else if (hush_arm && !hush_cancel)
		begin
			hush_q       <= 1'b1;
			hush_ticks_q <= 6'h00;
		end
		else if (hush_cancel || hush_expire)
		begin
			hush_q       <= 1'b0;                                            // see RL1 see RL2
			hush_ticks_q <= 6'h00;
		end
		else if (hush_q && tick)
		begin
			hush_ticks_q <= hush_ticks_q + 6'h01;
		end
	end

	// temporal pattern: three half-second bursts, then a 1.5 s gap
	assign half_tick   = half_cnt_q == HALF_PHASE - 1;
	assign temporal_on = (phase_q == 3'h0) || (phase_q == 3'h2) || (phase_q == 3'h4);
	assign pattern     = cfg_q[BIT_TONE] ? 1'b1 : temporal_on;                // see RL5
	assign alarm       = standby && sync_q[PIN_LOCAL] && !hush_q;

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			half_cnt_q <= 32'h0000_0000;
			phase_q    <= 3'h0;
		end
		else
		begin
			half_cnt_q <= half_tick ? 32'h0000_0000 : half_cnt_q + 32'h0000_0001;
			phase_q    <= half_tick ? phase_q + 3'h1 : phase_q;
		end
	end

	// registered outputs
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			horn_o           <= 1'b0;
			red_indicator_o  <= 1'b0;
			monitor_output_o <= 1'b0;
			smoke_power_o    <= 1'b0;
			lowbat_check_o   <= 1'b0;
			chamber_low_o    <= 1'b0;
			hush_active_o    <= 1'b0;
			ee_write_o       <= 1'b0;
		end
		else
		begin
			horn_o           <= (state_q == ST_HORN) || (alarm && pattern);  // see RL8
			red_indicator_o  <= lbt_q || win_on[WIN_LED];                     // see RL9 see RL16
			monitor_output_o <= lbt_q && sync_q[PIN_LOWBAT];                  // see RL10
			smoke_power_o    <= win_on[WIN_SMOKE];
			lowbat_check_o   <= win_on[WIN_LB] || lbt_q;
			chamber_low_o    <= win_on[WIN_CHAMBER];
			hush_active_o    <= hush_q;
			ee_write_o       <= cfg_store || lock_write || eol_step;
		end
	end

	assign lock_bit_o    = lock_q;
	assign test_mode_o   = mode_q;
	assign config_word_o = cfg_q;
	assign life_count_o  = life_q;

endmodule // dtm_sequencer

// [testbench/dtm_sequencer_properties.sv]
/*
 * port assertions for the test-mode sequencer.
 * assumes the bind below hands on the shortened window parameters.
 */
module dtm_sequencer_checker
	import dtm_pkg::*;
#(
	parameter int unsigned SMOKE_WIN   = SMOKE_WIN_CYC,
	parameter int unsigned CHAMBER_LOW = CHAMBER_LOW_CYC
)(
	input wire logic                ref_clk_i,
	input wire logic                reset_i,
	input wire logic                battery_low_i,
	input wire logic                horn_o,
	input wire logic                red_indicator_o,
	input wire logic                monitor_output_o,
	input wire logic                smoke_power_o,
	input wire logic                chamber_low_o,
	input wire logic                hush_active_o,
	input wire logic                ee_write_o,
	input wire logic                lock_bit_o,
	input wire logic [4:0]          test_mode_o,
	input wire logic [CFG_BITS-1:0] config_word_o
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge ref_clk_i);
	endclocking

	// run lengths counted here: a repetition cannot take a parameter
	logic [15:0] smoke_run_q;
	logic [15:0] cham_run_q;

	always_ff @(posedge ref_clk_i)
	begin
		smoke_run_q <= (reset_i || !smoke_power_o) ? 16'h0000 : smoke_run_q + 16'h0001;
		cham_run_q  <= (reset_i || !chamber_low_o) ? 16'h0000 : cham_run_q + 16'h0001;
	end

	a_reset_quiet: assert property (reset_i |=> !horn_o && !lock_bit_o && !ee_write_o
		&& test_mode_o == 5'h00) else $error("outputs not cleared after reset");
	a_mode_step_one: assert property (disable iff (reset_i) $changed(test_mode_o)
		|-> test_mode_o == $past(test_mode_o) + 5'h01) else $error("mode did not step by one");
	a_horn_holds: assert property (disable iff (reset_i)
		test_mode_o == MODE_HORN && horn_o |=> horn_o) else $error("horn test dropped");
	a_lock_write: assert property (disable iff (reset_i) $rose(lock_bit_o)
		|-> test_mode_o == MODE_LOCK && ee_write_o) else $error("lock set without store");
	a_lock_blocks: assert property (disable iff (reset_i) lock_bit_o
		|=> $stable(config_word_o)) else $error("stored word changed while locked");
	a_store_pulse: assert property (disable iff (reset_i)
		ee_write_o |=> !ee_write_o) else $error("store pulse longer than one cycle");
	a_smoke_window: assert property (disable iff (reset_i) $fell(smoke_power_o)
		|-> smoke_run_q == 16'(SMOKE_WIN)) else $error("smoke window length wrong");
	a_chamber_window: assert property (disable iff (reset_i) $fell(chamber_low_o)
		|-> cham_run_q == 16'(CHAMBER_LOW)) else $error("chamber low length wrong");
	a_monitor_follow: assert property (disable iff (reset_i) $rose(battery_low_i)
		&& red_indicator_o && test_mode_o == MODE_LOW_BATTERY |-> ##[1:6] monitor_output_o)
		else $error("monitor did not follow low battery");
	a_hush_allowed: assert property (disable iff (reset_i) $rose(hush_active_o)
		|-> !config_word_o[BIT_HUSH_DIS]) else $error("hush armed while disabled");
endmodule // dtm_sequencer_checker

bind dtm_sequencer dtm_sequencer_checker #(.SMOKE_WIN(SMOKE_WIN), .CHAMBER_LOW(CHAMBER_LOW)) chk (
	.ref_clk_i(ref_clk_i), .reset_i(reset_i), .battery_low_i(battery_low_i), .horn_o(horn_o),
	.red_indicator_o(red_indicator_o), .monitor_output_o(monitor_output_o),
	.smoke_power_o(smoke_power_o), .chamber_low_o(chamber_low_o),
	.hush_active_o(hush_active_o), .ee_write_o(ee_write_o), .lock_bit_o(lock_bit_o),
	.test_mode_o(test_mode_o), .config_word_o(config_word_o));

// [testbench/dtm_sequencer_test.sv]
/*
 * self-checking bench: standby schedule, hush, horn, battery, serial, lock.
 * assumes the shortened timing parameters set on the instance below.
 */
module dtm_sequencer_test
	import dtm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned TK = 200;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic battery_low_i = 1'b0;
	logic high_smoke_i = 1'b0;
	logic local_smoke_i = 1'b0;
	logic button_i = 1'b0;
	logic remote_smoke_i = 1'b0;
	logic test_pin, io_pin, feed_pin, step_pin;
	logic horn_o, red_o, mon_o, smoke_o, lbc_o, cham_o, hush_o, ee_o, lock_o;
	logic [4:0] mode_o;
	logic [CFG_BITS-1:0] cfg_o;
	logic [LIFE_W-1:0] life_o;
	int miscompares = 0;
	int compares = 0;
	int n;

	always #50 ref_clk_i = ~ref_clk_i;

	dtm_tester tester (.ref_clk_i(ref_clk_i), .test_pin_o(test_pin), .io_pin_o(io_pin),
		.feed_pin_o(feed_pin), .mode_step_pin_o(step_pin));

	dtm_sequencer #(.SMOKE_WIN(5), .LB_WIN(8), .LED_WIN(8), .CHAMBER_LOW(50), .TICK(TK),
		.HALF_PHASE(4)) uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .test_pin_i(test_pin),
		.io_pin_i(io_pin), .feed_pin_i(feed_pin), .mode_step_pin_i(step_pin),
		.battery_low_i(battery_low_i), .high_smoke_i(high_smoke_i),
		.remote_smoke_i(remote_smoke_i),
		.local_smoke_i(local_smoke_i), .push_button_check_i(button_i), .horn_o(horn_o),
		.red_indicator_o(red_o), .monitor_output_o(mon_o), .smoke_power_o(smoke_o),
		.lowbat_check_o(lbc_o), .chamber_low_o(cham_o), .hush_active_o(hush_o),
		.ee_write_o(ee_o), .lock_bit_o(lock_o), .test_mode_o(mode_o), .config_word_o(cfg_o),
		.life_count_o(life_o));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic restart;
		tester.idle();
		reset_i = 1'b1;
		tester.cyc(5);
		reset_i = 1'b0;
		tester.cyc(1);
	endtask

	// the release is what arms hush; the level needs three cycles to get through
	task automatic press;
		button_i = 1'b1;
		tester.cyc(4);
		button_i = 1'b0;
		tester.cyc(6);
	endtask

	task automatic wait_smoke(output int k);
		k = 0;
		while (smoke_o !== 1'b1 && k < 500)
		begin
			tester.cyc(1);
			k++;
		end
	endtask

	initial
	begin
		restart();
		check({horn_o, lock_o, ee_o, mode_o}, 0);
		wait_smoke(n);
		check({lbc_o, red_o, cham_o}, 3'h7);
		tester.cyc(6);
		wait_smoke(n);
		check(n + 6, TK);
		check({lbc_o, red_o, cham_o}, 3'h0);
		// release arms hush with the reset word: 9 minute timeout, temporal tone
		local_smoke_i = 1'b1;
		button_i = 1'b1;
		tester.cyc(6);
		button_i = 1'b0;
		tester.cyc(8);
		check(hush_o, 1);
		high_smoke_i = 1'b1;
		tester.cyc(20);
		check({hush_o, horn_o}, 2'h2);
		n = 28;
		while (hush_o === 1'b1 && n < 12000)
		begin
			tester.cyc(1);
			n++;
		end
		check(n > 53 * TK && n <= 54 * TK + 10, 1);
		n = 0;
		repeat (32)
		begin
			tester.cyc(1);
			n += int'(horn_o === 1'b1);
		end
		check(n, 12);
		check(life_o, 0);
		{local_smoke_i, high_smoke_i} = 2'h0;
		restart();
		tester.select(3);
		check(mode_o, MODE_HORN);
		tester.test_pin_o = 1'b0;
		tester.step(1);
		check({horn_o, mode_o}, {1'b1, MODE_HORN});
		restart();
		check(mode_o, 0);
		tester.select(17);
		check(mode_o, MODE_LOW_BATTERY);
		tester.test_pin_o = 1'b0;
		tester.step(1);
		check(mode_o, MODE_LOW_BATTERY);
		battery_low_i = 1'b1;
		tester.io_pulse(1'b1);
		check({red_o, mon_o}, 2'h3);
		battery_low_i = 1'b0;
		tester.cyc(8);
		check(mon_o, 0);
		battery_low_i = 1'b1;
		tester.cyc(8);
		check({mon_o, lbc_o}, 2'h3);
		restart();
		tester.select(18);
		tester.shift(35'h5_A5C3_0F12);
		tester.io_pulse(1'b1);
		check(cfg_o, 35'h5_A5C3_0F12);
		press();
		check(hush_o, 0);
		// second word: hush allowed, only in local smoke, smart cancel on
		tester.shift(35'h0_0000_000C);
		tester.io_pulse(1'b1);
		check(cfg_o, 35'h0_0000_000C);
		press();
		check(hush_o, 0);
		local_smoke_i = 1'b1;
		press();
		check(hush_o, 1);
		remote_smoke_i = 1'b1;
		tester.cyc(6);
		check(hush_o, 0);
		remote_smoke_i = 1'b0;
		press();
		check(hush_o, 1);
		high_smoke_i = 1'b1;
		tester.cyc(6);
		check(hush_o, 0);
		{local_smoke_i, high_smoke_i} = 2'h0;
		tester.step(1);
		tester.io_pulse(1'b1);
		check({mode_o, lock_o}, {MODE_LOCK, 1'b1});
		tester.io_pulse(1'b0);
		check(lock_o, 0);
		conclude();
	end

	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		miscompares++;
		conclude();
	end
endmodule // dtm_sequencer_test

// [testbench/dtm_tester.sv]
/*
 * production tester model driving the mode-step, test, io and feed pins.
 * assumes its tasks are called by the bench just after a rising clock edge.
 */
module dtm_tester (
	input wire logic ref_clk_i,
	output logic     test_pin_o,
	output logic     io_pin_o,
	output logic     feed_pin_o,
	output logic     mode_step_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// every level is held at least 4 cycles: the pins pass two sync flops first
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic idle;
		{test_pin_o, io_pin_o, feed_pin_o, mode_step_pin_o} = 4'h0;
	endtask

	task automatic step(input int n);
		repeat (n)
		begin
			cyc(4);
			mode_step_pin_o = 1'b0;
			cyc(4);
			mode_step_pin_o = 1'b1;
		end
		cyc(4);
	endtask

	task automatic select(input int n);
		mode_step_pin_o = 1'b1;
		cyc(4);
		test_pin_o = 1'b1;
		step(n);
	endtask

	task automatic io_pulse(input logic t);
		test_pin_o = t;
		cyc(4);
		io_pin_o = 1'b1;
		cyc(4);
		io_pin_o = 1'b0;
		cyc(8);
	endtask

	task automatic shift(input logic [34:0] w);
		for (int i = 0; i < 35; i++)
		begin
			test_pin_o = w[i];
			cyc(4);
			feed_pin_o = 1'b1;
			cyc(4);
			feed_pin_o = 1'b0;
		end
	endtask

	initial
		idle();
endmodule // dtm_tester
